// *** hdl/irb_defines.svh ***
// Register offsets, field positions, reset values and state counts.
`ifndef IRB_DEFINES_SVH
`define IRB_DEFINES_SVH

// Register byte offsets on the register bus.
`define IRB_OFS_BRK_CTRL   12'h000
`define IRB_OFS_BRK_ADDR   12'h004
`define IRB_OFS_XFER_EN    12'h008
`define IRB_OFS_POST_SEL   12'h00c
`define IRB_OFS_LEVEL      12'h010
`define IRB_OFS_CPU_PEND   12'h014
`define IRB_OFS_XFER_PEND  12'h018
`define IRB_OFS_LATENCY    12'h01c

// Field positions in break_control_register.
`define IRB_BIT_BRK_EN     0
`define IRB_BIT_BRK_FLAG   1
`define IRB_BIT_ADV_MODE   8

// Reset values.
`define IRB_RST_BRK_ADDR   23'h000000
`define IRB_RST_XFER_EN    8'h00
`define IRB_RST_POST_SEL   8'h00
`define IRB_RST_LEVEL      9'h000

// Exception entry costs, all in states of mclk.
`define IRB_PRIO_EXT_ST    3
`define IRB_PRIO_INT_ST    2
`define IRB_FETCH_ST       1
`define IRB_INSN_MAX_BASE  19
`define IRB_STACK_ST       2
`define IRB_VEC_NORMAL_ST  1
`define IRB_VEC_ADV_ST     2
`define IRB_PROC_ST        1

`endif

// *** hdl/irb_pkg.sv ***
// Types shared by the interrupt routing and address break block.
package irb_pkg;

    // Exception entry sequencer, one-hot.
    typedef enum logic [9:0] {
        IRB_IDLE    = 10'h001,
        IRB_PRIO    = 10'h002,
        IRB_WAIT    = 10'h004,
        IRB_FETCH1  = 10'h008,
        IRB_PROC1   = 10'h010,
        IRB_STACK   = 10'h020,
        IRB_VECTOR  = 10'h040,
        IRB_PROC2   = 10'h080,
        IRB_FETCH2  = 10'h100,
        IRB_START   = 10'h200
    } irb_entry_e;

    typedef logic [8:0] irb_src_t;

endpackage

// *** hdl/irb_top.sv ***
// Interrupt routing, exception entry timing and address break comparator.
`timescale 1ns/1ns
`include "irb_defines.svh"

module irb_top
    import irb_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt sources: two external pins, six internal levels.
    input  wire logic [1:0]  ext_irq_pin,
    input  wire logic [5:0]  int_src,
    // CPU mask bits and instruction progress.
    input  wire logic        mask_i,
    input  wire logic        upper_level_mask,
    input  wire logic        insn_done,
    input  wire logic        prefetch_strobe,
    input  wire logic [23:0] prefetch_addr,
    // Exception entry towards the CPU.
    output logic             cpu_irq_req,
    output logic [3:0]       cpu_vector,
    output logic [9:0]       entry_phase,
    output logic             handler_start,
    // Transfer engine handshake.
    output logic             xfer_req,
    output logic [2:0]       xfer_src,
    input  wire logic        xfer_done,
    input  wire logic        xfer_cnt_zero
);

    // Index of the break source in the CPU pending vector.
    localparam logic [3:0] BRK_IDX = 4'h8;

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    logic        brk_en_ff;
    logic        brk_flag_ff;
    logic        adv_mode_ff;
    logic [23:1] brk_addr_ff;
    logic [7:0]  xfer_en_ff;
    logic [7:0]  post_sel_ff;
    irb_src_t    level_ff;
    logic [7:0]  cpu_pend_ff;
    logic [7:0]  xfer_pend_ff;
    logic [7:0]  src_prev_ff;
    logic [1:0]  ext_s1_ff;
    logic [1:0]  ext_s2_ff;
    logic        xfer_busy_ff;
    logic [2:0]  xfer_src_ff;
    irb_entry_e  state_ff;
    irb_entry_e  nxt_state;
    logic [4:0]  st_cnt_ff;
    logic [4:0]  nxt_st_cnt;
    logic [3:0]  vec_ff;
    logic [5:0]  lat_cnt_ff;
    logic [5:0]  lat_last_ff;
    logic [31:0] prdata_ff;

    logic [7:0]  src_lvl;
    logic [7:0]  src_rise;
    logic        wr_en;
    logic        rd_setup;
    logic        addr_ok;
    logic        brk_hit;
    logic        brk_req;
    irb_src_t    cpu_cand;
    logic        cpu_any;
    logic [3:0]  cpu_win;
    logic        xfer_any;
    logic [2:0]  xfer_win;
    logic        accept;
    logic        xfer_fin;
    logic [7:0]  fin_mask;
    logic [7:0]  take_mask;
    logic [7:0]  dec_post;

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------

    // Every register answers at once, so pready never stalls.
    always_comb
    begin
        unique case (paddr)
            `IRB_OFS_BRK_CTRL,
            `IRB_OFS_BRK_ADDR,
            `IRB_OFS_XFER_EN,
            `IRB_OFS_POST_SEL,
            `IRB_OFS_LEVEL,
            `IRB_OFS_CPU_PEND,
            `IRB_OFS_XFER_PEND,
            `IRB_OFS_LATENCY: addr_ok = 1'b1;
            default:          addr_ok = 1'b0;
        endcase
    end

    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_ok;
    assign wr_en    = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign prdata   = prdata_ff;

    // Read data is captured in the setup cycle so it leaves a flop.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            prdata_ff <= 32'h00000000;
        else if (rd_setup)
        begin
            prdata_ff <= 32'h00000000;
            unique case (paddr)
                `IRB_OFS_BRK_CTRL:
                begin
                    prdata_ff[`IRB_BIT_BRK_EN]   <= brk_en_ff;
                    prdata_ff[`IRB_BIT_BRK_FLAG] <= brk_flag_ff;
                    prdata_ff[`IRB_BIT_ADV_MODE] <= adv_mode_ff;
                end
                `IRB_OFS_BRK_ADDR:  prdata_ff[23:1] <= brk_addr_ff;
                `IRB_OFS_XFER_EN:   prdata_ff[7:0]  <= xfer_en_ff;
                `IRB_OFS_POST_SEL:  prdata_ff[7:0]  <= post_sel_ff;
                `IRB_OFS_LEVEL:     prdata_ff[8:0]  <= level_ff;
                `IRB_OFS_CPU_PEND:  prdata_ff[8:0]  <= cpu_cand;
                `IRB_OFS_XFER_PEND:
                begin
                    prdata_ff[7:0]  <= xfer_pend_ff;
                    prdata_ff[8]    <= xfer_busy_ff;
                    prdata_ff[11:9] <= xfer_src_ff;
                end
                `IRB_OFS_LATENCY:   prdata_ff[5:0]  <= lat_last_ff;
                default:            prdata_ff       <= 32'h00000000;
            endcase
        end
    end

    //------------------------------------------------------------
    // Address break
    //------------------------------------------------------------

    // Bit zero never takes part; normal mode drops the top byte too.
    always_comb
    begin
        if (adv_mode_ff)
            brk_hit = prefetch_addr[23:1] == brk_addr_ff;
        else
            brk_hit = prefetch_addr[15:1] == brk_addr_ff[15:1];
    end

    // Any prefetch counts, including one caused by a branch just before.
    assign brk_req = brk_flag_ff & brk_en_ff;

    // Match flag: set wins over a software clear in the same cycle.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            brk_flag_ff <= 1'b0;
        else if (brk_en_ff & prefetch_strobe & brk_hit)
            brk_flag_ff <= 1'b1;
        else if (wr_en && paddr == `IRB_OFS_BRK_CTRL &&
                 !pwdata[`IRB_BIT_BRK_FLAG])
            brk_flag_ff <= 1'b0;
    end

    // Break control and address registers.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            brk_en_ff   <= 1'b0;
            adv_mode_ff <= 1'b0;
            brk_addr_ff <= `IRB_RST_BRK_ADDR;
        end
        else if (wr_en)
        begin
            if (paddr == `IRB_OFS_BRK_CTRL)
            begin
                brk_en_ff   <= pwdata[`IRB_BIT_BRK_EN];
                adv_mode_ff <= pwdata[`IRB_BIT_ADV_MODE];
            end
            if (paddr == `IRB_OFS_BRK_ADDR)
                brk_addr_ff <= pwdata[23:1];
        end
    end

    // Level and post-transfer select registers.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level_ff    <= `IRB_RST_LEVEL;
            post_sel_ff <= `IRB_RST_POST_SEL;
        end
        else if (wr_en)
        begin
            if (paddr == `IRB_OFS_LEVEL)
                level_ff <= pwdata[8:0];
            if (paddr == `IRB_OFS_POST_SEL)
                post_sel_ff <= pwdata[7:0];
        end
    end

    //------------------------------------------------------------
    // Source capture and routing
    //------------------------------------------------------------

    // External pins cross into mclk through two flops.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_s1_ff   <= 2'b00;
            ext_s2_ff   <= 2'b00;
            src_prev_ff <= 8'h00;
        end
        else
        begin
            ext_s1_ff   <= ext_irq_pin;
            ext_s2_ff   <= ext_s1_ff;
            src_prev_ff <= src_lvl;
        end
    end

    assign src_lvl  = {int_src, ext_s2_ff};
    assign src_rise = src_lvl & ~src_prev_ff;

    // Finished transfer, and the sources it hands to the CPU.
    assign xfer_fin = xfer_busy_ff & xfer_done;
    assign dec_post = 8'h01 << xfer_src_ff;
    always_comb
    begin
        fin_mask = 8'h00;
        if (xfer_fin && (xfer_cnt_zero || post_sel_ff[xfer_src_ff]))
            fin_mask = dec_post;
    end

    // Transfer enable: a finishing transfer clears over a software write.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            xfer_en_ff <= `IRB_RST_XFER_EN;
        else if (wr_en && paddr == `IRB_OFS_XFER_EN)
            xfer_en_ff <= pwdata[7:0] & ~fin_mask;
        else
            xfer_en_ff <= xfer_en_ff & ~fin_mask;
    end

    // A rising source goes to the engine or the CPU, per enable bit.
    // Both-way routing reaches the CPU only after the transfer ends.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            xfer_pend_ff <= 8'h00;
        else
            xfer_pend_ff <= (xfer_pend_ff & ~take_mask)
                            | (src_rise & xfer_en_ff);
    end

    // CPU pending bits are cleared when the CPU accepts them.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            cpu_pend_ff <= 8'h00;
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if ((src_rise[i] & ~xfer_en_ff[i]) | fin_mask[i])
                    cpu_pend_ff[i] <= 1'b1;
                else if (accept && vec_ff == 4'(i))
                    cpu_pend_ff[i] <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // Transfer engine arbitration
    //------------------------------------------------------------

    // Fixed default order, lowest index first; masks are not looked at.
    always_comb
    begin
        xfer_any = |xfer_pend_ff;
        xfer_win = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (xfer_pend_ff[i])
                xfer_win = 3'(i);
        end
    end

    assign take_mask = (~xfer_busy_ff & xfer_any) ? (8'h01 << xfer_win)
                                                   : 8'h00;

    // One transfer at a time; the request holds until done.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xfer_busy_ff <= 1'b0;
            xfer_src_ff  <= 3'h0;
        end
        else if (!xfer_busy_ff && xfer_any)
        begin
            xfer_busy_ff <= 1'b1;
            xfer_src_ff  <= xfer_win;
        end
        else if (xfer_fin)
            xfer_busy_ff <= 1'b0;
    end

    assign xfer_req = xfer_busy_ff;
    assign xfer_src = xfer_src_ff;

    //------------------------------------------------------------
    // CPU candidate selection
    //------------------------------------------------------------

    // Masked sources are held pending; the break bypasses both masks.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            cpu_cand[i] = cpu_pend_ff[i] &
                          (~mask_i | (level_ff[i] & ~upper_level_mask));
        cpu_cand[8] = brk_req;
    end

    // Level one wins first, then default order by index.
    always_comb
    begin
        cpu_any = |cpu_cand;
        cpu_win = 4'h0;
        for (int i = 8; i >= 0; i--)
        begin
            if (cpu_cand[i] && !level_ff[i])
                cpu_win = 4'(i);
        end
        for (int i = 8; i >= 0; i--)
        begin
            if (cpu_cand[i] && level_ff[i])
                cpu_win = 4'(i);
        end
    end

    //------------------------------------------------------------
    // Exception entry sequencer
    //------------------------------------------------------------

    // Acceptance happens when the instruction in flight has ended or the wait count runs out.
    assign accept = state_ff == IRB_WAIT &&
                    (insn_done || st_cnt_ff == 5'd1);

    // The state counter holds the states left in the current phase.
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_st_cnt = st_cnt_ff - 5'd1;
        unique case (state_ff)
            IRB_IDLE:
            begin
                nxt_st_cnt = st_cnt_ff;
                if (cpu_any)
                begin
                    nxt_state  = IRB_PRIO;
                    nxt_st_cnt = (cpu_win < 4'h2)
                        ? 5'(`IRB_PRIO_EXT_ST)
                        : 5'(`IRB_PRIO_INT_ST);
                end
            end
            IRB_PRIO:
                if (st_cnt_ff == 5'd1)
                begin
                    nxt_state  = IRB_WAIT;
                    nxt_st_cnt = 5'(`IRB_INSN_MAX_BASE
                                    + 2 * `IRB_FETCH_ST);
                end
            IRB_WAIT:
                if (accept)
                begin
                    nxt_state  = IRB_FETCH1;
                    nxt_st_cnt = 5'(`IRB_FETCH_ST);
                end
            IRB_FETCH1:
                if (st_cnt_ff == 5'd1)
                begin
                    nxt_state  = IRB_PROC1;
                    nxt_st_cnt = 5'(`IRB_PROC_ST);
                end
            IRB_PROC1:
                if (st_cnt_ff == 5'd1)
                begin
                    nxt_state  = IRB_STACK;
                    nxt_st_cnt = 5'(`IRB_STACK_ST);
                end
            IRB_STACK:
                if (st_cnt_ff == 5'd1)
                begin
                    nxt_state  = IRB_VECTOR;
                    nxt_st_cnt = adv_mode_ff
                        ? 5'(`IRB_VEC_ADV_ST)
                        : 5'(`IRB_VEC_NORMAL_ST);
                end
            IRB_VECTOR:
                if (st_cnt_ff == 5'd1)
                begin
                    nxt_state  = IRB_PROC2;
                    nxt_st_cnt = 5'(`IRB_PROC_ST);
                end
            IRB_PROC2:
                if (st_cnt_ff == 5'd1)
                begin
                    nxt_state  = IRB_FETCH2;
                    nxt_st_cnt = 5'(`IRB_FETCH_ST);
                end
            IRB_FETCH2:
                if (st_cnt_ff == 5'd1)
                begin
                    nxt_state  = IRB_START;
                    nxt_st_cnt = 5'd0;
                end
            IRB_START:
            begin
                nxt_state  = IRB_IDLE;
                nxt_st_cnt = 5'd0;
            end
            default:
            begin
                nxt_state  = IRB_IDLE;
                nxt_st_cnt = 5'd0;
            end
        endcase
    end

    // Sequencer state and phase counter.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff  <= IRB_IDLE;
            st_cnt_ff <= 5'd0;
        end
        else
        begin
            state_ff  <= nxt_state;
            st_cnt_ff <= nxt_st_cnt;
        end
    end

    // The winner is frozen at the start of priority determination.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            vec_ff <= 4'h0;
        else if (state_ff == IRB_IDLE && cpu_any)
            vec_ff <= cpu_win;
    end

    // Response time, from request taken to handler start, in states.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lat_cnt_ff  <= 6'd0;
            lat_last_ff <= 6'd0;
        end
        else if (state_ff == IRB_IDLE)
            lat_cnt_ff <= 6'd0;
        else if (state_ff == IRB_START)
            lat_last_ff <= lat_cnt_ff;
        else
            lat_cnt_ff <= lat_cnt_ff + 6'd1;
    end

    // Request stays up from priority determination until acceptance.
    assign cpu_irq_req   = state_ff == IRB_PRIO || state_ff == IRB_WAIT;
    assign cpu_vector    = vec_ff;
    assign entry_phase   = state_ff;
    assign handler_start = state_ff == IRB_START;

endmodule

// *** verification/irb_checker.sv ***
// Port checker for the interrupt routing and address break block.
`timescale 1ns/1ns
module irb_checker
(
    // Clock and reset.
    input wire logic       mclk,
    input wire logic       reset_n,
    // Watched ports.
    input wire logic       mask_i,
    input wire logic       insn_done,
    input wire logic       cpu_irq_req,
    input wire logic [3:0] cpu_vector,
    input wire logic [9:0] entry_phase,
    input wire logic       handler_start,
    input wire logic       xfer_req,
    input wire logic [2:0] xfer_src,
    input wire logic       xfer_done,
    input wire logic       xfer_cnt_zero
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // Every one-hot phase bit but idle, wait and vector must last exactly its own number of states.
    chk_prio_ext: assert property (
        $rose(entry_phase[1]) && cpu_vector < 4'h2
        |-> entry_phase[1] [*3] ##1 entry_phase[2])
        else $error("external priority length wrong");
    chk_prio_int: assert property (
        $rose(entry_phase[1]) && cpu_vector >= 4'h2
        |-> entry_phase[1] [*2] ##1 entry_phase[2])
        else $error("internal priority length wrong");
    chk_entry_mid: assert property (
        $fell(entry_phase[2]) |-> entry_phase[3] ##1 entry_phase[4]
        ##1 entry_phase[5] [*2] ##1 entry_phase[6])
        else $error("fetch, processing or stacking step wrong");
    chk_entry_tail: assert property (
        $fell(entry_phase[6]) |-> entry_phase[7] ##1 entry_phase[8]
        ##1 entry_phase[9] && handler_start ##1 !handler_start)
        else $error("entry tail or handler start wrong");
    chk_wait_bound: assert property (
        $rose(entry_phase[2]) |-> ##[1:21] !entry_phase[2])
        else $error("instruction wait too long");
    chk_wait_end: assert property (
        entry_phase[2] && insn_done |=> entry_phase[3])
        else $error("wait did not end at instruction end");
    chk_xfer_hold: assert property (
        xfer_req && !xfer_done |=> xfer_req && $stable(xfer_src))
        else $error("transfer request dropped early");
    chk_cpu_after: assert property (
        xfer_done && xfer_cnt_zero && !mask_i && entry_phase[0]
        |-> ##2 cpu_irq_req)
        else $error("no request after last transfer");

    cover property (handler_start && cpu_vector == 4'h8);
    cover property (xfer_done && xfer_cnt_zero);
    cover property (entry_phase[2] && insn_done);
endmodule

bind irb_top irb_checker u_irb_checker (
    .mclk, .reset_n, .mask_i, .insn_done, .cpu_irq_req, .cpu_vector,
    .entry_phase, .handler_start, .xfer_req, .xfer_src, .xfer_done,
    .xfer_cnt_zero
);

// *** verification/irb_partner.sv ***
// Behavioural CPU core and transfer engine facing the block.
`timescale 1ns/1ns
module irb_partner
(
    // Clock and reset.
    input wire logic       mclk,
    input wire logic       reset_n,
    // Pace set by the bench.
    input wire logic [4:0] insn_len,
    input wire logic [3:0] xfer_lat,
    input wire logic       cnt_zero_in,
    // Block side.
    input wire logic [9:0] entry_phase,
    input wire logic       xfer_req,
    output logic           insn_done,
    output logic           xfer_done,
    output logic           xfer_cnt_zero
);
    logic [4:0] wcnt_ff;
    logic [3:0] xcnt_ff;

    // Done flags come from counters, so they move only after an edge.
    assign insn_done = entry_phase[2] && wcnt_ff >= insn_len;
    assign xfer_done = xfer_req && xcnt_ff >= xfer_lat;
    // Outside the done pulse the count flag shows a stale, wrong level.
    assign xfer_cnt_zero = xfer_done ? cnt_zero_in : !cnt_zero_in;

    // Count states of the running instruction and of the transfer.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wcnt_ff <= 5'h00;
            xcnt_ff <= 4'h0;
        end
        else
        begin
            wcnt_ff <= (entry_phase[2] && !insn_done) ? wcnt_ff + 5'h01
                                                       : 5'h00;
            xcnt_ff <= (xfer_req && !xfer_done) ? xcnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for entry timing, routing and address break.
`timescale 1ns/1ns
`include "irb_defines.svh"
module testbench;
    logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic        mask_i, upper_level_mask, insn_done, prefetch_strobe;
    logic        cpu_irq_req, handler_start, xfer_req, xfer_done, slverr;
    logic        xfer_cnt_zero, cnt_zero_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  ext_irq_pin;
    logic [5:0]  int_src;
    logic [23:0] prefetch_addr;
    logic [3:0]  cpu_vector, xfer_lat;
    logic [9:0]  entry_phase;
    logic [2:0]  xfer_src;
    logic [4:0]  insn_len;
    logic [5:0]  adv_tab = 6'b101100;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          src_tab[6] = '{0, 1, 0, 1, 4, 7};
    int          len_tab[6] = '{0, 31, 0, 20, 5, 20};
    int          lat_tab[6] = '{11, 31, 12, 32, 15, 31};

    irb_top u_irb_top (
        .mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_irq_pin, .int_src, .mask_i,
        .upper_level_mask, .insn_done, .prefetch_strobe, .prefetch_addr,
        .cpu_irq_req, .cpu_vector, .entry_phase, .handler_start,
        .xfer_req, .xfer_src, .xfer_done, .xfer_cnt_zero
    );
    irb_partner u_irb_partner (
        .mclk, .reset_n, .insn_len, .xfer_lat, .cnt_zero_in, .entry_phase,
        .xfer_req, .insn_done, .xfer_done, .xfer_cnt_zero
    );

    // Clock at 10 MHz.
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // A hang counts as a mismatch and closes the run.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // Compare one value and count it.
    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; data and error are taken at the pready edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One prefetch cycle; the address is scrambled once released.
    task automatic fetch(input logic [23:0] a);
        @(posedge mclk);
        prefetch_strobe <= 1'b1;
        prefetch_addr <= a;
        @(posedge mclk);
        prefetch_strobe <= 1'b0;
        prefetch_addr <= ~a;
    endtask

    // Wait for a level; the global timeout bounds it.
    task automatic wait_for(ref logic sig, input logic val);
        while (sig !== val)
            @(posedge mclk);
    endtask

    // Raise one source and measure its whole entry.
    task automatic entry(input int i);
        apb(1'b1, `IRB_OFS_BRK_CTRL, {23'h0, adv_tab[i], 8'h00});
        insn_len <= len_tab[i][4:0];
        if (src_tab[i] < 2)
            ext_irq_pin[src_tab[i]] <= 1'b1;
        else
            int_src[src_tab[i] - 2] <= 1'b1;
        wait_for(handler_start, 1'b1);
        ext_irq_pin <= 2'b00;
        int_src <= 6'h00;
        chk("vector", src_tab[i], {28'h0, cpu_vector});
        apb(1'b0, `IRB_OFS_LATENCY, 32'h0);
        chk("latency", lat_tab[i], rd);
    endtask

    // Print the counts and the verdict, then end.
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence: registers, timing table, transfers, then breaks.
    initial
    begin
        {reset_n, psel, penable, pwrite, mask_i, upper_level_mask} = '0;
        {prefetch_strobe, cnt_zero_in, paddr, pwdata} = '0;
        {ext_irq_pin, int_src, prefetch_addr, insn_len, xfer_lat} = '0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        for (int a = 0; a < 32; a += 4)
        begin
            apb(1'b0, a[11:0], 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, slverr});
        apb(1'b1, `IRB_OFS_XFER_EN, 32'hffffffff);
        apb(1'b0, `IRB_OFS_XFER_EN, 32'h0);
        chk("enable width", 32'hff, rd);
        apb(1'b1, `IRB_OFS_XFER_EN, 32'h0);
        for (int i = 0; i < 6; i++)
            entry(i);
        mask_i <= 1'b1;
        xfer_lat <= 4'h5;
        apb(1'b1, `IRB_OFS_XFER_EN, 32'h28);
        apb(1'b1, `IRB_OFS_POST_SEL, 32'h20);
        int_src <= 6'h0a;
        wait_for(xfer_req, 1'b1);
        chk("first source", 32'h3, {29'h0, xfer_src});
        int_src <= 6'h00;
        wait_for(xfer_req, 1'b0);
        xfer_lat <= 4'h0;
        wait_for(xfer_req, 1'b1);
        chk("second source", 32'h5, {29'h0, xfer_src});
        wait_for(xfer_req, 1'b0);
        apb(1'b0, `IRB_OFS_XFER_EN, 32'h0);
        chk("enables left", 32'h08, rd);
        chk("masked", 32'h0, {31'h0, cpu_irq_req});
        mask_i <= 1'b0;
        wait_for(handler_start, 1'b1);
        chk("post vector", 32'h5, {28'h0, cpu_vector});
        cnt_zero_in <= 1'b1;
        int_src <= 6'h02;
        wait_for(xfer_req, 1'b1);
        chk("cpu held", 32'h0, {31'h0, cpu_irq_req});
        wait_for(handler_start, 1'b1);
        chk("zero vector", 32'h3, {28'h0, cpu_vector});
        int_src <= 6'h00;
        apb(1'b0, `IRB_OFS_XFER_EN, 32'h0);
        chk("zero enable", 32'h0, rd);
        mask_i <= 1'b1;
        apb(1'b1, `IRB_OFS_LEVEL, 32'h4);
        int_src <= 6'h01;
        wait_for(handler_start, 1'b1);
        chk("level vector", 32'h2, {28'h0, cpu_vector});
        int_src <= 6'h00;
        upper_level_mask <= 1'b1;
        apb(1'b1, `IRB_OFS_BRK_ADDR, 32'h123457);
        apb(1'b0, `IRB_OFS_BRK_ADDR, 32'h0);
        chk("break address", 32'h123456, rd);
        apb(1'b1, `IRB_OFS_BRK_CTRL, 32'h0);
        fetch(24'h123456);
        apb(1'b0, `IRB_OFS_BRK_CTRL, 32'h0);
        chk("break off", 32'h0, rd);
        apb(1'b1, `IRB_OFS_BRK_CTRL, 32'h1);
        fetch(24'hab3457);
        wait_for(handler_start, 1'b1);
        chk("brk vector", 32'h8, {28'h0, cpu_vector});
        apb(1'b0, `IRB_OFS_BRK_CTRL, 32'h0);
        chk("flag kept", 32'h3, rd);
        apb(1'b1, `IRB_OFS_BRK_CTRL, 32'h101);
        fetch(24'hab3456);
        apb(1'b0, `IRB_OFS_BRK_CTRL, 32'h0);
        chk("wide miss", 32'h101, rd);
        fetch(24'h123456);
        apb(1'b0, `IRB_OFS_BRK_CTRL, 32'h0);
        chk("wide hit", 32'h103, rd);
        stop_test();
    end
endmodule
